// file: bench/rtmr_core_asserts.sv
// Purpose: port-level checks of the reloadable timer core
// Assumes: sees only the core's ports, one clock domain
// Notes: bound to every rtmr_core instance at the foot
`timescale 1ns/100ps
`default_nettype none
module rtmr_core_asserts
   import rtmr_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [1:0] tmr_in_i,
   input wire logic [2:0] ext_clk_i,
   input wire logic [1:0] tmr_out_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // access phase and decode helpers
   wire logic acc = psel_i && penable_i;
   wire logic unmapped = paddr_i > RTMR_OFS_INTFL;
   wire logic wr_acc = acc && pwrite_i;
   property p_ready; acc |-> pready_o; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   // read data must outlive the access phase by a cycle
   property p_rd_hold; acc && !pwrite_i |=> $stable(prdata_o); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
   property p_err_map; acc && unmapped |-> pslverr_o; endproperty
   a_err_map: assert property (p_err_map) else $error("no slverr");
   property p_rd_zero;
      acc && !pwrite_i && unmapped |-> prdata_o == 32'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("hole nonzero");
   property p_err_ok;
      acc && paddr_i[1:0] == 2'h0 && !unmapped |-> !pslverr_o;
   endproperty
   a_err_ok: assert property (p_err_ok) else $error("bad slverr");
   property p_err_idle; !acc |-> !pslverr_o; endproperty
   a_err_idle: assert property (p_err_idle) else $error("idle slverr");
   property p_rst_irq; $rose(resetn_i) |-> !irq_o && !wake_o; endproperty
   a_rst_irq: assert property (p_rst_irq) else $error("irq at reset");
   property p_rst_out;
      $rose(resetn_i) |-> tmr_out_o == 2'b00 && prdata_o == 32'h0;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("out at reset");
   // flag stands until software writes, irq follows a cycle late
   property p_irq_hold;
      irq_o && !wr_acc && !$past(wr_acc) |=> irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
   c_irq: cover property ($rose(irq_o));
   c_out_b: cover property ($changed(tmr_out_o[1]));
   c_err: cover property (pslverr_o);
endmodule : rtmr_core_asserts
bind rtmr_core rtmr_core_asserts i_rtmr_core_asserts (
   .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .tmr_in_i(tmr_in_i),
   .ext_clk_i(ext_clk_i), .tmr_out_o(tmr_out_o), .irq_o(irq_o),
   .wake_o(wake_o));
`default_nettype wire

// file: bench/rtmr_pin_model.sv
// Purpose: pins on the far side of the timer core
// Assumes: pin edges are unrelated to the system clock
// Notes: external sources run only while switched on
`timescale 1ns/100ps
`default_nettype none
module rtmr_pin_model (
   input wire logic [2:0] ext_run_i,
   output logic [1:0] tmr_in_o,
   output logic [2:0] ext_clk_o
);
   initial begin
      tmr_in_o = 2'b00;
      ext_clk_o = 3'b000;
   end
   // 40 ns source, stands still when switched off
   always #20 ext_clk_o = ext_clk_o ^ ext_run_i;
   // odd delays keep edges off the clock grid
   task pulse(input int h, input int n);
      repeat (n) begin
         #37 tmr_in_o[h] = 1'b1;
         #41 tmr_in_o[h] = 1'b0;
      end
   endtask : pulse
endmodule : rtmr_pin_model
`default_nettype wire

// file: bench/tb_rtmr_core.sv
// Purpose: self-checking bench of the reloadable timer core
// Assumes: apb slave without wait states, pins from the pin model
// Notes: register checks first, then period table, then hand-written mode cases
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_rtmr_core
   import rtmr_pkg::*;
;
   logic clock_i, resetn_i, psel_i, penable_i, pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i;
   logic [3:0] pstrb_i;
   logic [2:0] ext_run;
   wire logic [31:0] prdata_o;
   wire logic pready_o, pslverr_o, irq_o, wake_o;
   wire logic [1:0] tmr_in_i, tmr_out_o;
   wire logic [2:0] ext_clk_i;
   int n_mismatch = 0;
   int cmp_count = 0;
   int pres[4] = '{0, 1, 3, 0};
   int src[4] = '{0, 0, 0, 1};
   int expg[4] = '{3, 6, 12, 12};
   rtmr_core i_rtmr_core (.clock_i(clock_i), .resetn_i(resetn_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .tmr_in_i(tmr_in_i), .ext_clk_i(ext_clk_i), .tmr_out_o(tmr_out_o),
      .irq_o(irq_o), .wake_o(wake_o));
   rtmr_pin_model i_rtmr_pin_model (.ext_run_i(ext_run),
      .tmr_in_o(tmr_in_i), .ext_clk_o(ext_clk_i));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // one apb transfer, held until pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r);
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready_o !== 1'b1);
      r = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask : wr
   task rd(input logic [11:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask : rd
   // status polling is bounded, a hang shows as a mismatch
   task poll(input int pos, input logic v);
      logic [31:0] r;
      for (int k = 0; k < 40; k++) begin
         rd(RTMR_OFS_CTRL1, r);
         if (r[pos] === v) break;
      end
      `CHK(r[pos], v)
   endtask : poll
   // stop, configure, start clock, then enable one half
   task start(input logic [31:0] c0, input logic [31:0] c1,
              input logic [31:0] cmp, input int h);
      wr(RTMR_OFS_CTRL0, 32'h0);
      poll(RTMR_CLKRUN_POS + 16 * h, 1'b0);
      wr(RTMR_OFS_CTRL1, c1);
      wr(RTMR_OFS_COMPARE, cmp);
      wr(RTMR_OFS_COUNT, RTMR_RELOAD);
      wr(RTMR_OFS_INTFL, 32'h0001_0001);
      wr(RTMR_OFS_CTRL0, c0 & ~(32'h20 << (16 * h)));
      poll(RTMR_CLKRDY_POS + 16 * h, 1'b1);
      wr(RTMR_OFS_CTRL0, c0);
      poll(RTMR_CLKRUN_POS + 16 * h, 1'b1);
   endtask : start
   // cycles between two successive output toggles
   task gap(input int b, output int g);
      logic p;
      int t1;
      g = -1;
      t1 = -1;
      @(posedge clock_i);
      p = tmr_out_o[b];
      for (int k = 0; k < 400; k++) begin
         @(posedge clock_i);
         if (tmr_out_o[b] !== p) begin
            p = tmr_out_o[b];
            if (t1 >= 0) begin
               g = k - t1;
               break;
            end
            t1 = k;
         end
      end
   endtask : gap
   task print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   // whole run is a few hundred cycles; 30000 is ample
   initial begin
      #300000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      logic [31:0] r, c;
      int g;
      resetn_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      pstrb_i = 4'hf;
      ext_run = 3'b000;
      repeat (4) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(RTMR_OFS_COUNT, r);
      `CHK(r, 32'h0000_0000)
      rd(RTMR_OFS_COMPARE, r);
      `CHK(r, 32'hffff_ffff)
      wr(RTMR_OFS_PWM, 32'h8765_4321);
      rd(RTMR_OFS_PWM, r);
      `CHK(r, 32'h8765_4321)
      wr(12'h020, 32'hdead_beef);
      rd(12'h020, r);
      `CHK(r, 32'h0)
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         ext_run <= {2'b00, src[i] != 0};
         start(32'h0000_00e1, 32'((src[i] << 12) | pres[i]), 32'h3, 0);
         gap(0, g);
         `CHK(g, expg[i])
         `CHK(irq_o, 1'b1)
         rd(RTMR_OFS_COUNT, r);
         `CHK(r >= 1 && r <= 3, 1'b1)
         $display("period row %0d done", i);
      end
      ext_run <= 3'b000;
      wr(RTMR_OFS_CTRL0, 32'h0);
      wr(RTMR_OFS_INTFL, 32'h0000_0001);
      rd(RTMR_OFS_INTFL, r);
      `CHK(r, 32'h0)
      `CHK(irq_o, 1'b0)
      start(32'h40e1_0000, 32'h0, 32'h0003_ffff, 1);
      gap(1, g);
      `CHK(g, 3)
      rd(RTMR_OFS_COUNT, r);
      `CHK(r[15:0], 16'h0001)
      $display("dual half done");
      start(32'h0000_0160, 32'h0, 32'h2, 0);
      repeat (20) @(posedge clock_i);
      rd(RTMR_OFS_COUNT, r);
      repeat (10) @(posedge clock_i);
      rd(RTMR_OFS_COUNT, c);
      `CHK(c, r)
      rd(RTMR_OFS_INTFL, r);
      `CHK(r[0], 1'b1)
      `CHK(irq_o, 1'b0)
      `CHK(wake_o, 1'b1)
      $display("one-shot done");
      start(32'h0000_0062, 32'h0, 32'hffff_ffff, 0);
      i_rtmr_pin_model.pulse(0, 5);
      repeat (10) @(posedge clock_i);
      rd(RTMR_OFS_COUNT, r);
      `CHK(r, 32'd6)
      start(32'h0000_0066, 32'h0, 32'hffff_ffff, 0);
      repeat (10) @(posedge clock_i);
      rd(RTMR_OFS_COUNT, r);
      `CHK(r, RTMR_RELOAD)
      start(32'h0000_0064, 32'h0, 32'hffff_ffff, 0);
      i_rtmr_pin_model.pulse(0, 1);
      repeat (10) @(posedge clock_i);
      rd(RTMR_OFS_PWM, r);
      rd(RTMR_OFS_COUNT, c);
      `CHK(r != 0 && r < c, 1'b1)
      rd(RTMR_OFS_INTFL, r);
      `CHK(r[0], 1'b1)
      $display("pin modes done");
      // pwm: off for counts 1 and 2, on for 3 and 4
      wr(RTMR_OFS_CTRL0, 32'h0);
      wr(RTMR_OFS_PWM, 32'h3);
      start(32'h0000_0063, 32'h0, 32'h4, 0);
      gap(0, g);
      `CHK(g, 2)
      // capture/compare: reload plus four high ticks
      start(32'h0000_0067, 32'h0, 32'hffff_ffff, 0);
      i_rtmr_pin_model.pulse(0, 1);
      repeat (10) @(posedge clock_i);
      rd(RTMR_OFS_PWM, r);
      rd(RTMR_OFS_COUNT, c);
      `CHK(r, 32'd5)
      `CHK(c, RTMR_RELOAD)
      $display("pwm and capcmp done");
      // reset in mid-run while enabled, count back at its reset value of zero
      resetn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(RTMR_OFS_COUNT, r);
      `CHK(r, RTMR_COUNT_RST)
      `CHK(tmr_out_o, 2'b00)
      $display("mid-run reset done");
      print_verdict();
   end
endmodule : tb_rtmr_core
`default_nettype wire

// file: hdl/rtmr_core.sv
// Purpose: reloadable 32-bit or dual 16-bit timer with apb registers
// Assumes: one clock, synchronous active-low reset, async pins
// Notes: pins and external clock sources pass two flip-flops first
//
// Summary of operation
// - count advances on prescaled clock, input pin, or both, per mode
// - count register is readable at any time, also while counting
// - period ends on the timer tick after the end condition is met
// - period end sets flag; interrupt raised only when enabled
// - count reloads to one at period end; reset value is zero
// - 32-bit modes: low half fields govern, all 32 bits used
// - single 16-bit mode: low half fields control, high ignored
// - dual 16-bit: high fields drive bits 31..16, low bits 15..0
// - count clock equals source divided by prescaler 1 to 4096
// - clock source and prescaler selectable per half in dual mode
// - pin events latched on next timer tick edge
// - clock-gate status reads zero only once timer really stopped
// - clock-ready status rises once selected source is running
// - one-shot counts to terminal and halts; continuous repeats
// - counter mode advances once per qualifying input edge
// - capture mode snapshots count on selected input transition
// - compare mode toggles output when count passes terminal
// - gated mode increments only while input is asserted
// - capture/compare counts while asserted, captures on deassert
// - pwm output with software configurable off-time
// - timer keeps running and can raise a wake request
// - mode codes 0,1,2,3,4,5,6,7,8,14; others reserved
// - output modes are one-shot, continuous, pwm 3 and compare
`timescale 1ns/100ps
`default_nettype none

module rtmr_core
   import rtmr_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [1:0] tmr_in_i,
   input wire logic [2:0] ext_clk_i,
   output logic [1:0] tmr_out_o,
   output logic irq_o,
   output logic wake_o
);

   // byte-lane merge of a write into the old word
   function automatic logic [31:0] rtmr_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : rtmr_merge

   logic [31:0] count_q;
   logic [31:0] compare_q;
   logic [31:0] pwm_q;
   rtmr_half_ctrl_type ctrl_a_q;
   rtmr_half_ctrl_type ctrl_b_q;
   logic [1:0] org_q;
   rtmr_half_clk_type clk_a_q;
   rtmr_half_clk_type clk_b_q;
   logic [31:0] intfl_q;
   logic [31:0] prdata_q;
   logic irq_q;
   logic wake_q;
   logic [1:0] in_s1_q;
   logic [1:0] in_s2_q;
   logic [2:0] ck_s1_q;
   logic [2:0] ck_s2_q;
   logic [2:0] ck_prev_q;
   logic [3:0] src_edge;
   logic dual;
   logic wide;
   logic setup;
   logic access;
   logic addr_hit;
   logic wr_en;
   logic [31:0] rd_mux;
   logic [31:0] rd_ctrl0;
   logic [31:0] rd_ctrl1;
   logic [31:0] wmerged;
   logic [31:0] count_hw;
   logic [31:0] pwm_hw;

   // two-stage synchronisers for pins and external clock sources
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         in_s1_q <= 2'h0;
         in_s2_q <= 2'h0;
         ck_s1_q <= 3'h0;
         ck_s2_q <= 3'h0;
         ck_prev_q <= 3'h0;
      end else begin
         in_s1_q <= tmr_in_i;
         in_s2_q <= in_s1_q;
         ck_s1_q <= ext_clk_i;
         ck_s2_q <= ck_s1_q;
         ck_prev_q <= ck_s2_q;
      end
   end

   // source 0 is the bus clock itself, 1..3 rising edges of the pins
   assign src_edge = {ck_s2_q & ~ck_prev_q, 1'b1};
   assign wide = (org_q == RTMR_ORG_32);
   assign dual = (org_q == RTMR_ORG_DUAL16);

   // one counting unit per half; unit 1 only lives in dual mode
   for (genvar h = 0; h < 2; h++) begin : g_unit
      localparam int unsigned SH = RTMR_HALF_B_POS * h;
      rtmr_half_ctrl_type c;
      rtmr_half_clk_type k;
      logic act;
      logic [31:0] mask;
      logic [31:0] v;
      logic [31:0] cmpv;
      logic [31:0] pwmv;
      logic [31:0] step;
      logic [31:0] nx;
      logic hit;
      logic src;
      logic tick;
      logic lvl;
      logic rise;
      logic fall;
      logic ev;
      logic cp;
      logic tg;
      logic [11:0] pcnt_q;
      logic run_q;
      logic rdy_q;
      logic pin_q;
      logic halt_q;
      logic out_q;

      // unit 1 ignored outside dual mode
      assign c = (h == 0) ? ctrl_a_q : ctrl_b_q;
      assign k = (h == 0) ? clk_a_q : clk_b_q;
      assign act = (h == 0) | dual;
      assign mask = (h == 0 && wide) ? RTMR_MASK32 : RTMR_MASK16;
      assign v = (count_q >> SH) & mask;
      assign cmpv = (compare_q >> SH) & mask;
      assign pwmv = (pwm_q >> SH) & mask;
      assign hit = (v == cmpv);
      // count equal to terminal last tick: this tick ends the period
      assign step = hit ? RTMR_RELOAD : ((v + 32'h1) & mask);
      assign src = src_edge[k.clk_sel];
      // divide by prescale+1, field 0..4095 gives 1..4096
      assign tick = run_q & ~halt_q & src & (pcnt_q == k.prescale);
      assign lvl = in_s2_q[h] ^ c.polarity;
      assign rise = tick & lvl & ~pin_q;
      assign fall = tick & ~lvl & pin_q;

      // prescaler counts source edges while running
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            pcnt_q <= RTMR_PCNT_RST;
         end else if (!run_q || tick) begin
            pcnt_q <= RTMR_PCNT_RST;
         end else if (src) begin
            pcnt_q <= pcnt_q + 12'h1;
         end
      end

      // source ready once enabled and seen running
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            rdy_q <= 1'b0;
         end else if (!(act && c.clk_en)) begin
            rdy_q <= 1'b0;
         end else if (k.clk_sel == 2'h0 || src) begin
            rdy_q <= 1'b1;
         end
      end

      // running flag is what gates counting, so status cannot lie
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            run_q <= 1'b0;
         end else begin
            run_q <= act & c.enable & c.clk_en & rdy_q;
         end
      end

      // pin level sampled only at timer ticks
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            pin_q <= 1'b0;
         end else if (tick) begin
            pin_q <= lvl;
         end
      end

      // one-shot halt, released by clearing the enable
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            halt_q <= 1'b0;
         end else if (!c.enable) begin
            halt_q <= 1'b0;
         end else if (ev && c.mode == RTMR_MODE_ONESHOT) begin
            halt_q <= 1'b1;
         end
      end

      // per-mode next count, event, capture and toggle
      always_comb begin
         nx = v;
         ev = 1'b0;
         cp = 1'b0;
         tg = 1'b0;
         unique case (c.mode)
            RTMR_MODE_ONESHOT, RTMR_MODE_CONT, RTMR_MODE_PWM,
            RTMR_MODE_COMPARE: begin
               if (tick) begin
                  nx = step;
                  ev = hit;
                  tg = hit;
               end
            end
            RTMR_MODE_COUNTER: begin
               if (rise) begin
                  nx = step;
                  ev = hit;
               end
            end
            RTMR_MODE_CAPTURE: begin
               if (tick) begin
                  nx = step;
                  ev = hit | rise;
                  cp = rise;
               end
            end
            RTMR_MODE_GATED: begin
               if (tick && lvl) begin
                  nx = step;
                  ev = hit;
               end
            end
            RTMR_MODE_CAPCMP: begin
               if (fall) begin
                  nx = RTMR_RELOAD;
                  ev = 1'b1;
                  cp = 1'b1;
               end else if (tick && lvl) begin
                  nx = step;
                  ev = hit;
               end
            end
            RTMR_MODE_DUALCAP: begin
               if (tick) begin
                  nx = step;
                  ev = hit | rise | fall;
                  cp = rise | fall;
               end
            end
            RTMR_MODE_INACTGATED: begin
               if (tick && !lvl) begin
                  nx = step;
                  ev = hit;
               end
            end
            default: begin
               nx = v; // reserved codes hold the count
            end
         endcase
      end

      // output pin level, polarity applied at the port
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            out_q <= 1'b0;
         end else if (!run_q) begin
            out_q <= 1'b0;
         end else if (c.mode == RTMR_MODE_PWM) begin
            // off while the count is below the pwm value, on until period end
            out_q <= (nx >= pwmv);
         end else if (tg) begin
            out_q <= ~out_q;
         end
      end

      assign tmr_out_o[h] = out_q ^ c.polarity;
   end

   // hardware count and capture results merged into full words
   always_comb begin
      if (wide) begin
         count_hw = g_unit[0].nx;
         pwm_hw = g_unit[0].cp ? g_unit[0].v : pwm_q;
      end else begin
         count_hw[15:0] = g_unit[0].nx[15:0];
         pwm_hw[15:0] = g_unit[0].cp ? g_unit[0].v[15:0] : pwm_q[15:0];
         if (dual) begin
            count_hw[31:16] = g_unit[1].nx[15:0];
            pwm_hw[31:16] = g_unit[1].cp ? g_unit[1].v[15:0] : pwm_q[31:16];
         end else begin
            count_hw[31:16] = count_q[31:16];
            pwm_hw[31:16] = pwm_q[31:16];
         end
      end
   end

   // apb decode: read data loaded in setup, answer without waits
   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign addr_hit = (paddr_i == RTMR_OFS_COUNT) ||
                     (paddr_i == RTMR_OFS_COMPARE) ||
                     (paddr_i == RTMR_OFS_PWM) ||
                     (paddr_i == RTMR_OFS_CTRL0) ||
                     (paddr_i == RTMR_OFS_CTRL1) ||
                     (paddr_i == RTMR_OFS_INTFL);
   assign wr_en = access & pwrite_i & addr_hit;
   assign pready_o = 1'b1;
   assign pslverr_o = access & ~addr_hit;
   assign prdata_o = prdata_q;

   // readback words of the control registers
   assign rd_ctrl0 = {org_q, 5'h00, ctrl_b_q, 7'h00, ctrl_a_q};
   assign rd_ctrl1 = {g_unit[1].run_q, g_unit[1].rdy_q, clk_b_q,
                      g_unit[0].run_q, g_unit[0].rdy_q, clk_a_q};

   // read multiplexer, unmapped reads as zero
   always_comb begin
      unique case (paddr_i)
         RTMR_OFS_COUNT: rd_mux = count_q;
         RTMR_OFS_COMPARE: rd_mux = compare_q;
         RTMR_OFS_PWM: rd_mux = pwm_q;
         RTMR_OFS_CTRL0: rd_mux = rd_ctrl0;
         RTMR_OFS_CTRL1: rd_mux = rd_ctrl1;
         RTMR_OFS_INTFL: rd_mux = intfl_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // old word merged with byte lanes of the write
   always_comb begin
      unique case (paddr_i)
         RTMR_OFS_COUNT: wmerged = rtmr_merge(count_q, pwdata_i, pstrb_i);
         RTMR_OFS_COMPARE: wmerged = rtmr_merge(compare_q, pwdata_i, pstrb_i);
         RTMR_OFS_PWM: wmerged = rtmr_merge(pwm_q, pwdata_i, pstrb_i);
         RTMR_OFS_CTRL0: wmerged = rtmr_merge(rd_ctrl0, pwdata_i, pstrb_i);
         RTMR_OFS_CTRL1: wmerged = rtmr_merge(rd_ctrl1, pwdata_i, pstrb_i);
         default: wmerged = pwdata_i;
      endcase
   end

   // read data register
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   // count: software preload wins over the running count
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         count_q <= RTMR_COUNT_RST;
      end else if (wr_en && paddr_i == RTMR_OFS_COUNT) begin
         count_q <= wmerged;
      end else begin
         count_q <= count_hw;
      end
   end

   // compare value, software only
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         compare_q <= RTMR_COMPARE_RST;
      end else if (wr_en && paddr_i == RTMR_OFS_COMPARE) begin
         compare_q <= wmerged;
      end
   end

   // pwm value, also the capture landing place
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         pwm_q <= RTMR_PWM_RST;
      end else if (wr_en && paddr_i == RTMR_OFS_PWM) begin
         pwm_q <= wmerged;
      end else begin
         pwm_q <= pwm_hw;
      end
   end

   // control fields; no write lockout while running, a user hazard
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         ctrl_a_q <= RTMR_CTRL_RST;
         ctrl_b_q <= RTMR_CTRL_RST;
         org_q <= RTMR_ORG_32;
         clk_a_q <= RTMR_CLK_RST;
         clk_b_q <= RTMR_CLK_RST;
      end else if (wr_en && paddr_i == RTMR_OFS_CTRL0) begin
         ctrl_a_q <= wmerged[$bits(rtmr_half_ctrl_type)-1:0];
         ctrl_b_q <= wmerged[RTMR_HALF_B_POS +: $bits(rtmr_half_ctrl_type)];
         org_q <= wmerged[RTMR_ORG_POS +: 2];
      end else if (wr_en && paddr_i == RTMR_OFS_CTRL1) begin
         clk_a_q <= wmerged[$bits(rtmr_half_clk_type)-1:0];
         clk_b_q <= wmerged[RTMR_HALF_B_POS +: $bits(rtmr_half_clk_type)];
      end
   end

   // flags: write one to clear, a new event wins over the clear
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         intfl_q <= 32'h0000_0000;
      end else begin
         intfl_q[0] <= (intfl_q[0] &
                        ~(wr_en && paddr_i == RTMR_OFS_INTFL &&
                          pstrb_i[0] && pwdata_i[0])) |
                       g_unit[0].ev;
         intfl_q[RTMR_HALF_B_POS] <= (intfl_q[RTMR_HALF_B_POS] &
                        ~(wr_en && paddr_i == RTMR_OFS_INTFL &&
                          pstrb_i[2] && pwdata_i[RTMR_HALF_B_POS])) |
                       g_unit[1].ev;
      end
   end

   // interrupt and wake requests gated by their enables
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         irq_q <= (intfl_q[0] & ctrl_a_q.irq_en) |
                  (intfl_q[RTMR_HALF_B_POS] & ctrl_b_q.irq_en & dual);
         wake_q <= (intfl_q[0] & ctrl_a_q.wake_en) |
                   (intfl_q[RTMR_HALF_B_POS] & ctrl_b_q.wake_en & dual);
      end
   end

   assign irq_o = irq_q;
   assign wake_o = wake_q;

endmodule : rtmr_core

`default_nettype wire

// file: hdl/rtmr_pkg.sv
// Purpose: shared constants and types of the reloadable timer core
// Assumes: apb slave with 12-bit byte addresses, 32-bit data
// Notes: register offsets of control, flag registers chosen locally
package rtmr_pkg;

   // register byte offsets
   localparam logic [11:0] RTMR_OFS_COUNT = 12'h000;
   localparam logic [11:0] RTMR_OFS_COMPARE = 12'h004;
   localparam logic [11:0] RTMR_OFS_PWM = 12'h008;
   localparam logic [11:0] RTMR_OFS_CTRL0 = 12'h00c;
   localparam logic [11:0] RTMR_OFS_CTRL1 = 12'h010;
   localparam logic [11:0] RTMR_OFS_INTFL = 12'h014;

   // values after reset and the reload value
   localparam logic [31:0] RTMR_COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] RTMR_COMPARE_RST = 32'hffff_ffff;
   localparam logic [31:0] RTMR_PWM_RST = 32'h0000_0000;
   localparam logic [31:0] RTMR_RELOAD = 32'h0000_0001;
   localparam logic [31:0] RTMR_MASK32 = 32'hffff_ffff;
   localparam logic [31:0] RTMR_MASK16 = 32'h0000_ffff;

   // mode field codes
   localparam logic [3:0] RTMR_MODE_ONESHOT = 4'h0;
   localparam logic [3:0] RTMR_MODE_CONT = 4'h1;
   localparam logic [3:0] RTMR_MODE_COUNTER = 4'h2;
   localparam logic [3:0] RTMR_MODE_PWM = 4'h3;
   localparam logic [3:0] RTMR_MODE_CAPTURE = 4'h4;
   localparam logic [3:0] RTMR_MODE_COMPARE = 4'h5;
   localparam logic [3:0] RTMR_MODE_GATED = 4'h6;
   localparam logic [3:0] RTMR_MODE_CAPCMP = 4'h7;
   localparam logic [3:0] RTMR_MODE_DUALCAP = 4'h8;
   localparam logic [3:0] RTMR_MODE_INACTGATED = 4'he;

   // timer organisation codes
   localparam logic [1:0] RTMR_ORG_32 = 2'h0;
   localparam logic [1:0] RTMR_ORG_DUAL16 = 2'h1;
   localparam logic [1:0] RTMR_ORG_SINGLE16 = 2'h2;

   // field positions
   localparam int unsigned RTMR_HALF_B_POS = 16;
   localparam int unsigned RTMR_ORG_POS = 30;
   localparam int unsigned RTMR_CLKRDY_POS = 14;
   localparam int unsigned RTMR_CLKRUN_POS = 15;
   localparam int unsigned RTMR_PRES_W = 12;

   // reset values of control fields
   localparam logic [8:0] RTMR_CTRL_RST = 9'h000;
   localparam logic [13:0] RTMR_CLK_RST = 14'h0000;
   localparam logic [11:0] RTMR_PCNT_RST = 12'h000;

   // per-half control fields, low half at bit 0, high half at bit 16
   typedef struct packed {
      logic wake_en;
      logic irq_en;
      logic clk_en;
      logic enable;
      logic polarity;
      logic [3:0] mode;
   } rtmr_half_ctrl_type;

   // per-half clock fields
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [11:0] prescale;
   } rtmr_half_clk_type;

endpackage : rtmr_pkg
